// ### core/program_memory_scanner.sv
// Purpose: fetches program memory words and hands them to the CRC engine
// Assumes: APB slave with no wait states on reads and writes
// Notes: memory answers each request with a one-cycle memAck
//
// Design decision made here: the APB register port.
`include "scanner_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module program_memory_scanner
    import scanner_pkg::*;
(
    input  wire logic                    core_clk,
    input  wire logic                    rst_n,
    // APB slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [`PADDR_W-1:0]     paddr,
    input  wire logic [31:0]             pwdata,
    output logic [31:0]                  prdata,
    output logic                         pready,
    output logic                         pslverr,
    // CRC engine
    input  wire logic                    crcEngineEnable,
    input  wire logic                    crcEngineGo,
    input  wire logic                    crcReady,
    output logic [`DATA_W-1:0]           crcData,
    output logic                         crcValid,
    // program flash array
    output logic                         memReq,
    output logic [`ADDR_W-1:0]           memAddr,
    input  wire logic                    memAck,
    input  wire logic [`DATA_W-1:0]      memRdata,
    input  wire logic                    cpuMemBusy,
    output logic                         cpuStall,
    // interrupt response of the core
    input  wire logic                    intrActive,
    // trigger sources
    input  wire logic                    lowFreqInternalOsc,
    input  wire logic                    referenceClockOut,
    input  wire logic [`NUM_TIMERS-1:0]  timerOut,
    input  wire logic [`NUM_CELLS-1:0]   logicCellOut,
    // interrupt
    output logic                         irq
);
    function automatic logic isIdx(input logic [`PADDR_W-1:0] a,
                                   input logic [11:0] idx);
        isIdx = (a == {idx, 2'b00});
    endfunction

    // register state
    logic [`ADDR_W-1:0]  curAddr_reg;
    logic [`ADDR_W-1:0]  curAddr_next;
    logic [`ADDR_W-1:0]  endAddr_reg;
    logic [`ADDR_W-1:0]  endAddr_next;
    logic [4:0]          trigSel_reg;
    logic [4:0]          trigSel_next;
    logic                enable_reg;
    logic                enable_next;
    logic                go_reg;
    logic                go_next;
    logic                invalid_reg;
    logic                invalid_next;
    logic                interrupt_management_mode_reg;
    logic                interrupt_management_mode_next;
    access_mode_type     mode_reg;
    access_mode_type     mode_next;
    logic [`IRQ_W-1:0]   irqStat_reg;
    logic [`IRQ_W-1:0]   irqStat_next;
    logic [`IRQ_W-1:0]   irqMask_reg;
    logic [`IRQ_W-1:0]   irqMask_next;
    scan_state_type      state_reg;
    scan_state_type      state_next;
    logic                trigPend_reg;
    logic                trigPend_next;
    logic [`DATA_W-1:0]  data_reg;
    logic [`DATA_W-1:0]  data_next;
    logic [31:0]         prdata_reg;
    logic [31:0]         prdata_next;

    // bus decode
    logic selStart;
    logic selEnd;
    logic selCtrl;
    logic selTrig;
    logic selStat;
    logic selMask;
    logic mapped;
    logic setupPhase;
    logic wrAccess;
    assign selStart   = isIdx(paddr, `IDX_START);
    assign selEnd     = isIdx(paddr, `IDX_END);
    assign selCtrl    = isIdx(paddr, `IDX_CTRL);
    assign selTrig    = isIdx(paddr, `IDX_TRIG);
    assign selStat    = isIdx(paddr, `IDX_IRQ_STAT);
    assign selMask    = isIdx(paddr, `IDX_IRQ_MASK);
    assign mapped     = selStart | selEnd | selCtrl | selTrig |
                        selStat | selMask;
    assign setupPhase = psel & ~penable;
    assign wrAccess   = psel & penable & pwrite & mapped;

    // go as seen by the engine
    logic intrMask;
    logic goEff;
    logic busy;
    logic trigPulse;
    logic allowFetch;
    logic startFetch;
    logic atEnd;
    logic wrapAddr;
    logic wrGoSet;
    logic crcRunning;
    // peek mode ignores the interrupt mode bit
    assign intrMask   = interrupt_management_mode_reg & intrActive & (mode_reg != MODE_PEEK);
    assign goEff      = go_reg & enable_reg & ~intrMask;
    assign busy       = (state_reg != ST_IDLE) |
                        (enable_reg & go_reg & crcReady);
    assign allowFetch = (mode_reg == MODE_TRIGGERED) ? trigPend_reg :
                        (mode_reg == MODE_PEEK) ? ~cpuMemBusy :
                        1'b1;
    assign startFetch = (state_reg == ST_IDLE) & goEff & crcReady &
                        allowFetch & ~atEnd & ~invalid_reg;
    // strict compare: start equal to end still fetches that one word
    assign atEnd      = curAddr_reg > endAddr_reg;
    assign wrapAddr   = (curAddr_reg == `MAP_LAST);
    assign crcRunning = crcEngineEnable & crcEngineGo;
    assign wrGoSet    = wrAccess & selCtrl & pwdata[`CTRL_GO];

    scan_trigger_sel u_trig (
        .core_clk           (core_clk),
        .rst_n              (rst_n),
        .triggerSelect      (trigSel_reg),
        .lowFreqInternalOsc (lowFreqInternalOsc),
        .referenceClockOut  (referenceClockOut),
        .timerOut           (timerOut),
        .logicCellOut       (logicCellOut),
        .triggerPulse       (trigPulse)
    );

    // scan engine
    logic fetchDone;
    logic doneEvt;
    logic invalidEvt;
    assign fetchDone = (state_reg == ST_FETCH) & memAck;

    always_comb begin
        state_next    = state_reg;
        trigPend_next = trigPend_reg;
        data_next     = data_reg;
        if (mode_reg == MODE_TRIGGERED && trigPulse) begin
            trigPend_next = 1'b1;
        end
        case (state_reg)
            ST_IDLE: begin
                if (startFetch) begin
                    state_next    = ST_FETCH;
                    trigPend_next = 1'b0;
                end
            end
            ST_FETCH: begin
                if (memAck) begin
                    data_next  = memRdata;
                    state_next = ST_HANDOFF;
                end
            end
            ST_HANDOFF: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        // disable overrides any transition, so a cut fetch is dropped
        if (!enable_reg) begin
            state_next    = ST_IDLE;
            trigPend_next = 1'b0;
        end
    end

    // go ends once the address passes the end, between data cycles
    assign doneEvt    = go_reg & atEnd & (state_reg == ST_IDLE);
    assign invalidEvt = (fetchDone & wrapAddr) |
                        (wrGoSet & ~go_reg & ~crcRunning);

    // register writes and hardware updates
    logic addrWrOk;
    assign addrWrOk = wrAccess & ~go_reg;

    always_comb begin
        curAddr_next = curAddr_reg;
        endAddr_next = endAddr_reg;
        trigSel_next = trigSel_reg;
        enable_next  = enable_reg;
        go_next      = go_reg;
        invalid_next = invalid_reg;
        interrupt_management_mode_next    = interrupt_management_mode_reg;
        mode_next    = mode_reg;
        irqMask_next = irqMask_reg;
        irqStat_next = irqStat_reg;
        if (addrWrOk && selStart) begin
            curAddr_next = pwdata[`ADDR_W-1:0];
            invalid_next = pwdata[`ADDR_W-1:0] > `MAP_LAST;
        end
        if (addrWrOk && selEnd) begin
            endAddr_next = pwdata[`ADDR_W-1:0];
        end
        if (wrAccess && selTrig) begin
            trigSel_next = pwdata[4:0];
        end
        if (wrAccess && selMask) begin
            irqMask_next = pwdata[`IRQ_W-1:0];
        end
        if (wrAccess && selCtrl) begin
            enable_next = pwdata[`CTRL_EN];
            interrupt_management_mode_next   = pwdata[`CTRL_INTERRUPT_MANAGEMENT_MODE];
            mode_next   = access_mode_type'(
                pwdata[`CTRL_MODE_HI:`CTRL_MODE_LO]);
            go_next     = pwdata[`CTRL_GO];
        end
        if (fetchDone) begin
            curAddr_next = wrapAddr ? `START_RESET :
                           curAddr_reg + 1'b1;
        end
        if (doneEvt && !wrGoSet) begin
            go_next = 1'b0;
        end
        if (invalidEvt) begin
            invalid_next = 1'b1;
            go_next      = 1'b0;
        end
        // set wins over the write-one clear
        if (wrAccess && selStat) begin
            irqStat_next = irqStat_reg & ~pwdata[`IRQ_W-1:0];
        end
        if (doneEvt) begin
            irqStat_next[`IRQ_DONE] = 1'b1;
        end
        if (invalidEvt) begin
            irqStat_next[`IRQ_INVALID] = 1'b1;
        end
    end

    // read mux, sampled in the setup phase
    logic [31:0] ctrlRead;
    logic [31:0] readMux;
    assign ctrlRead = {24'h000000, enable_reg, go_reg, busy, invalid_reg,
                       interrupt_management_mode_reg, 1'b0, mode_reg};
    assign readMux  = selStart ? {10'h000, curAddr_reg} :
                      selEnd   ? {10'h000, endAddr_reg} :
                      selCtrl  ? ctrlRead :
                      selTrig  ? {27'h0000000, trigSel_reg} :
                      selStat  ? {30'h00000000, irqStat_reg} :
                      selMask  ? {30'h00000000, irqMask_reg} :
                      32'h00000000;
    assign prdata_next = (setupPhase && !pwrite) ? readMux : prdata_reg;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            curAddr_reg  <= `START_RESET;
            endAddr_reg  <= `END_RESET;
            trigSel_reg  <= `TRIG_RESET;
            enable_reg   <= 1'b0;
            go_reg       <= 1'b0;
            invalid_reg  <= `INVALID_RESET;
            interrupt_management_mode_reg     <= 1'b0;
            mode_reg     <= MODE_CONCURRENT;
            irqStat_reg  <= '0;
            irqMask_reg  <= '0;
            state_reg    <= ST_IDLE;
            trigPend_reg <= 1'b0;
            data_reg     <= '0;
            prdata_reg   <= 32'h00000000;
        end else begin
            curAddr_reg  <= curAddr_next;
            endAddr_reg  <= endAddr_next;
            trigSel_reg  <= trigSel_next;
            enable_reg   <= enable_next;
            go_reg       <= go_next;
            invalid_reg  <= invalid_next;
            interrupt_management_mode_reg     <= interrupt_management_mode_next;
            mode_reg     <= mode_next;
            irqStat_reg  <= irqStat_next;
            irqMask_reg  <= irqMask_next;
            state_reg    <= state_next;
            trigPend_reg <= trigPend_next;
            data_reg     <= data_next;
            prdata_reg   <= prdata_next;
        end
    end

    // outputs
    assign prdata   = prdata_reg;
    // no wait states: every access cycle completes at once
    assign pready   = psel & penable;
    assign pslverr  = psel & penable & ~mapped;
    assign memReq   = (state_reg == ST_FETCH);
    assign memAddr  = curAddr_reg;
    assign crcData  = data_reg;
    assign crcValid = (state_reg == ST_HANDOFF);
    // burst holds the core off for the whole scan, concurrent and triggered per fetch only, peek never
    assign cpuStall = (mode_reg == MODE_BURST) ? goEff :
                      ((mode_reg != MODE_PEEK) & memReq);
    assign irq      = |(irqStat_reg & irqMask_reg);
endmodule
`default_nettype wire

// ### core/scanner_defines.svh
// Purpose: constants of the program memory scanner
// Assumes: APB byte address is four times the register index
// Notes: Operation list below
`ifndef SCANNER_DEFINES_SVH
`define SCANNER_DEFINES_SVH

`define ADDR_W            22
`define DATA_W            16
`define PADDR_W           16
// register indices; byte address is index times four
`define IDX_START         12'hF44
`define IDX_END           12'hF47
`define IDX_CTRL          12'hF4A
`define IDX_TRIG          12'hF4B
`define IDX_IRQ_STAT      12'hF4C
`define IDX_IRQ_MASK      12'hF4D
`define START_RESET       22'h000000
`define END_RESET         22'h3FFFFF
`define TRIG_RESET        5'h00
// last mapped program memory word address
`define MAP_LAST          22'h00FFFF
// control register fields
`define CTRL_EN           7
`define CTRL_GO           6
`define CTRL_BUSY         5
`define CTRL_INVALID      4
`define CTRL_INTERRUPT_MANAGEMENT_MODE         3
`define CTRL_MODE_HI      1
`define CTRL_MODE_LO      0
`define INVALID_RESET     1'b1
// interrupt status fields
`define IRQ_DONE          0
`define IRQ_INVALID       1
`define IRQ_W             2
// trigger codes
`define TRIGGER_SELECT_LFOSC        5'h00
`define TRIGGER_SELECT_REFCLK       5'h01
`define TRIGGER_SELECT_TMR_FIRST    5'h02
`define TRIGGER_SELECT_TMR_LAST     5'h08
`define TRIGGER_SELECT_CELL_FIRST   5'h10
`define TRIGGER_SELECT_CELL_LAST    5'h17
`define NUM_TIMERS        7
`define NUM_CELLS         8

`endif

// ### core/scanner_pkg.sv
// Purpose: types of the program memory scanner
// Assumes: constants come from scanner_defines.svh
// Notes: mode codes follow the access mode field
package scanner_pkg;
    typedef enum logic [1:0] {
        MODE_CONCURRENT = 2'h0,
        MODE_BURST      = 2'h1,
        MODE_PEEK       = 2'h2,
        MODE_TRIGGERED  = 2'h3
    } access_mode_type;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FETCH,
        ST_HANDOFF
    } scan_state_type;
endpackage

// ### core/scan_trigger_sel.sv
// Purpose: trigger source selection and rising edge detection
// Assumes: all sources are synchronous to core_clk
// Notes: reserved codes select a constant low source
`include "scanner_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module scan_trigger_sel (
    input  wire logic                    core_clk,
    input  wire logic                    rst_n,
    input  wire logic [4:0]              triggerSelect,
    input  wire logic                    lowFreqInternalOsc,
    input  wire logic                    referenceClockOut,
    input  wire logic [`NUM_TIMERS-1:0]  timerOut,
    input  wire logic [`NUM_CELLS-1:0]   logicCellOut,
    output logic                         triggerPulse
);
    logic selLevel;
    logic prevLevel_reg;
    logic [4:0] tmrIdx;
    logic [4:0] cellIdx;
    logic isTmr;
    logic isCell;

    assign tmrIdx  = triggerSelect - `TRIGGER_SELECT_TMR_FIRST;
    assign cellIdx = triggerSelect - `TRIGGER_SELECT_CELL_FIRST;
    assign isTmr   = (triggerSelect >= `TRIGGER_SELECT_TMR_FIRST) &&
                     (triggerSelect <= `TRIGGER_SELECT_TMR_LAST);
    assign isCell  = (triggerSelect >= `TRIGGER_SELECT_CELL_FIRST) &&
                     (triggerSelect <= `TRIGGER_SELECT_CELL_LAST);

    assign selLevel = (triggerSelect == `TRIGGER_SELECT_LFOSC)  ? lowFreqInternalOsc :
                      (triggerSelect == `TRIGGER_SELECT_REFCLK) ? referenceClockOut :
                      isTmr  ? timerOut[tmrIdx[2:0]] :
                      isCell ? logicCellOut[cellIdx[2:0]] :
                      1'b0;

    // a change of select may fake one edge; harmless, at most one fetch
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prevLevel_reg <= 1'b0;
        end else begin
            prevLevel_reg <= selLevel;
        end
    end

    assign triggerPulse = selLevel & ~prevLevel_reg;
endmodule
`default_nettype wire

// ### dv/scanner_props.sv
// Purpose: port-level checks of the program memory scanner
// Assumes: control writes are seen on APB to follow mode and enable
// Notes: the shadow ignores hardware clearing of go, so only en,
//        interrupt_management_mode and mode bits are used from it
`include "scanner_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module scanner_props (
    input wire logic                core_clk,
    input wire logic                rst_n,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [`PADDR_W-1:0] paddr,
    input wire logic [31:0]         pwdata,
    input wire logic                crcReady,
    input wire logic [`DATA_W-1:0]  crcData,
    input wire logic                crcValid,
    input wire logic                memReq,
    input wire logic [`ADDR_W-1:0]  memAddr,
    input wire logic                memAck,
    input wire logic [`DATA_W-1:0]  memRdata,
    input wire logic                cpuStall,
    input wire logic                intrActive
);
    logic [7:0] ctrl_reg;
    wire logic  ctrlWr = psel && penable && pwrite && paddr == 16'h3D28;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) ctrl_reg <= 8'h00;
        else if (ctrlWr) ctrl_reg <= pwdata[7:0];
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    property p_wordPass;
        memReq && memAck |=> crcValid && crcData == $past(memRdata);
    endproperty
    a_wordPass: assert property (p_wordPass)
        else $error("fetched word not handed on");
    property p_addrStep;
        memReq && memAck |=> memAddr == $past(memAddr) + 22'h1
            || ($past(memAddr) == `MAP_LAST && memAddr == 22'h0);
    endproperty
    a_addrStep: assert property (p_addrStep)
        else $error("address did not step by one");
    property p_reqHold;
        memReq && !memAck |=> memReq && $stable(memAddr);
    endproperty
    a_reqHold: assert property (p_reqHold)
        else $error("fetch request dropped early");
    property p_gap;
        crcValid |-> !memReq ##1 !memReq;
    endproperty
    a_gap: assert property (p_gap)
        else $error("fetch started too soon");
    property p_readyNeeded;
        $rose(memReq) |-> $past(crcReady);
    endproperty
    a_readyNeeded: assert property (p_readyNeeded)
        else $error("fetch without crc ready");
    property p_intrHold;
        $past(ctrl_reg[3]) && $past(ctrl_reg[1:0]) != 2'h2
            && $past(intrActive) |-> !$rose(memReq);
    endproperty
    a_intrHold: assert property (p_intrHold)
        else $error("fetch during interrupt response");
    property p_enGate;
        !$past(ctrl_reg[7]) |-> !$rose(memReq);
    endproperty
    a_enGate: assert property (p_enGate)
        else $error("fetch while disabled");
    property p_stallConc;
        ctrl_reg[1:0] == 2'h0 |-> cpuStall == memReq;
    endproperty
    a_stallConc: assert property (p_stallConc)
        else $error("concurrent stall mismatch");
endmodule
bind program_memory_scanner scanner_props props_u (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .crcReady(crcReady), .crcData(crcData), .crcValid(crcValid),
    .memReq(memReq), .memAddr(memAddr), .memAck(memAck),
    .memRdata(memRdata), .cpuStall(cpuStall), .intrActive(intrActive));
`default_nettype wire

// ### dv/flash_model.sv
// Purpose: program flash array answering scanner fetches
// Assumes: word is the low 16 address bits xor a fixed pattern
// Notes: answers alternate prompt and three cycles late
`timescale 1ns/1ps
`default_nettype none
module flash_model (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        memReq,
    input  wire logic [21:0] memAddr,
    output logic             memAck,
    output logic [15:0]      memRdata
);
    logic [1:0] waitCnt;
    logic       slowNext;
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            memAck <= 1'b0;
            memRdata <= 16'h0000;
            waitCnt <= 2'h0;
            slowNext <= 1'b1;
        end else begin
            memAck <= 1'b0;
            // off the ack the data lines drift, never hold the word
            memRdata <= ~memRdata;
            if (memReq && !memAck && waitCnt != 2'h0) begin
                waitCnt <= waitCnt - 2'h1;
            end else if (memReq && !memAck) begin
                memAck <= 1'b1;
                memRdata <= memAddr[15:0] ^ 16'hA5C3;
                waitCnt <= slowNext ? 2'h3 : 2'h0;
                slowNext <= ~slowNext;
            end
        end
    end
endmodule
`default_nettype wire

// ### dv/tb.sv
// Purpose: self-checking bench of the program memory scanner
// Assumes: APB slave answers in the access cycle
// Notes: trigger sources move only inside the pulse task
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        errSeen;
    logic        crcEngineEnable = 1'b0;
    logic        crcEngineGo = 1'b0;
    logic        crcReady = 1'b0;
    logic [15:0] crcData;
    logic        crcValid;
    logic        memReq;
    logic [21:0] memAddr;
    logic        memAck;
    logic [15:0] memRdata;
    logic        cpuStall;
    logic        intrActive = 1'b0;
    logic [6:0]  timerOut = 7'h00;
    logic        cpuMemBusy = 1'b0;
    logic        lfOsc = 1'b0;
    logic        refClk = 1'b0;
    logic [7:0]  cellOut = 8'h00;
    logic        irq;
    logic [31:0] r;
    logic [21:0] expAddr = 22'h0;
    int          words = 0;
    int          fail_count = 0;
    int          cmp_count = 0;
    program_memory_scanner dut_u (.core_clk(core_clk), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .crcEngineEnable(crcEngineEnable),
        .crcEngineGo(crcEngineGo), .crcReady(crcReady),
        .crcData(crcData), .crcValid(crcValid), .memReq(memReq),
        .memAddr(memAddr), .memAck(memAck), .memRdata(memRdata),
        .cpuMemBusy(cpuMemBusy), .cpuStall(cpuStall),
        .intrActive(intrActive), .lowFreqInternalOsc(lfOsc),
        .referenceClockOut(refClk), .timerOut(timerOut),
        .logicCellOut(cellOut), .irq(irq));
    flash_model mem_u (.core_clk(core_clk), .rst_n(rst_n),
        .memReq(memReq), .memAddr(memAddr), .memAck(memAck),
        .memRdata(memRdata));
    always #12.5 core_clk = ~core_clk;
    task automatic checkVal(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic apbDo(input logic w, input logic [15:0] a,
                         input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            fail_count++;
            $display("unexpected at %0t: no pready", $time);
        end
        r = prdata;
        errSeen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic waitWords(input int n);
        int k;
        k = 0;
        while (words < n && k < 300) begin
            @(posedge core_clk);
            k++;
        end
        repeat (6) @(posedge core_clk);
    endtask
    always @(posedge core_clk) begin
        if (crcValid === 1'b1) begin
            checkVal(crcData, expAddr[15:0] ^ 16'hA5C3);
            expAddr = expAddr + 22'h1;
            words++;
        end
    end
    task automatic resetValues;
        apbDo(0, 16'h3D10, 0); checkVal(r, 32'h0);
        apbDo(0, 16'h3D1C, 0); checkVal(r, 32'h003FFFFF);
        apbDo(0, 16'h3D2C, 0); checkVal(r, 32'h0);
        apbDo(0, 16'h3D28, 0); checkVal(r, 32'h10);
        apbDo(0, 16'h3D38, 0); checkVal({31'h0, errSeen}, 32'h1);
    endtask
    task automatic badStart;
        apbDo(1, 16'h3D10, 32'h10000);
        apbDo(0, 16'h3D28, 0); checkVal(r, 32'h10);
        apbDo(1, 16'h3D10, 32'h10);
        apbDo(1, 16'h3D34, 32'h3);
        apbDo(1, 16'h3D28, 32'hC0);
        apbDo(0, 16'h3D28, 0); checkVal(r, 32'h90);
        checkVal({31'h0, irq}, 32'h1);
        apbDo(1, 16'h3D30, 32'h2);
        apbDo(0, 16'h3D30, 0); checkVal({31'h0, irq}, 32'h0);
    endtask
    task automatic scanRun;
        crcEngineEnable <= 1'b1;
        crcEngineGo <= 1'b1;
        intrActive <= 1'b1;
        apbDo(1, 16'h3D10, 32'h10);
        apbDo(1, 16'h3D1C, 32'h12);
        expAddr = 22'h10;
        words = 0;
        apbDo(1, 16'h3D28, 32'hC0);
        apbDo(1, 16'h3D10, 32'h20);
        apbDo(0, 16'h3D10, 0); checkVal(r, 32'h10);
        apbDo(0, 16'h3D28, 0); checkVal(r, 32'hC0);
        crcReady <= 1'b1;
        apbDo(0, 16'h3D28, 0); checkVal(r, 32'hE0);
        waitWords(3); checkVal(words, 3);
        apbDo(0, 16'h3D28, 0); checkVal(r, 32'h80);
        apbDo(0, 16'h3D10, 0); checkVal(r, 32'h13);
        apbDo(0, 16'h3D30, 0); checkVal({31'h0, irq}, 32'h1);
        apbDo(1, 16'h3D30, 32'h1);
    endtask
    task automatic rollover;
        apbDo(1, 16'h3D10, 32'hFFFF);
        apbDo(1, 16'h3D1C, 32'h3FFFFF);
        expAddr = 22'hFFFF;
        words = 0;
        apbDo(1, 16'h3D28, 32'hC0);
        waitWords(1); checkVal(words, 1);
        apbDo(0, 16'h3D28, 0); checkVal(r, 32'h90);
        apbDo(0, 16'h3D10, 0); checkVal(r, 32'h0);
        apbDo(1, 16'h3D30, 32'h3);
    endtask
    task automatic intrHold;
        apbDo(1, 16'h3D10, 32'h30);
        apbDo(1, 16'h3D1C, 32'h31);
        expAddr = 22'h30;
        words = 0;
        apbDo(1, 16'h3D28, 32'hC8);
        repeat (10) @(posedge core_clk);
        checkVal(words, 0);
        apbDo(0, 16'h3D28, 0); checkVal(r & 32'h40, 32'h40);
        intrActive <= 1'b0;
        waitWords(2); checkVal(words, 2);
    endtask
    task automatic disableKeeps;
        crcReady <= 1'b0;
        apbDo(1, 16'h3D2C, 32'h05);
        apbDo(1, 16'h3D10, 32'h40);
        apbDo(1, 16'h3D1C, 32'h50);
        words = 0;
        apbDo(1, 16'h3D28, 32'hC0);
        apbDo(1, 16'h3D28, 32'h40);
        crcReady <= 1'b1;
        repeat (10) @(posedge core_clk);
        checkVal(words, 0);
        apbDo(0, 16'h3D2C, 0); checkVal(r, 32'h05);
        apbDo(0, 16'h3D1C, 0); checkVal(r, 32'h50);
        apbDo(0, 16'h3D10, 0); checkVal(r, 32'h40);
        apbDo(0, 16'h3D28, 0); checkVal(r, 32'h40);
        apbDo(1, 16'h3D28, 32'h00);
    endtask
    task automatic pulse(input logic [16:0] m);
        @(posedge core_clk);
        {lfOsc, refClk, cellOut, timerOut} <= m;
        repeat (2) @(posedge core_clk);
        {lfOsc, refClk, cellOut, timerOut} <= 17'h00000;
        repeat (10) @(posedge core_clk);
    endtask
    task automatic triggered;
        apbDo(1, 16'h3D10, 32'h60);
        apbDo(1, 16'h3D1C, 32'h6F);
        expAddr = 22'h60;
        words = 0;
        apbDo(1, 16'h3D2C, 32'h18);
        apbDo(1, 16'h3D28, 32'hC3);
        pulse(7'h7F);
        checkVal(words, 0);
        for (int i = 0; i < 7; i++) begin
            apbDo(1, 16'h3D2C, 32'h2 + i);
            pulse(7'h1 << i);
            checkVal(words, i + 1);
        end
        apbDo(1, 16'h3D2C, 32'h17);
        pulse(17'h04000); checkVal(words, 8);
        apbDo(1, 16'h3D2C, 32'h01);
        pulse(17'h08000); checkVal(words, 9);
        apbDo(1, 16'h3D2C, 32'h00);
        pulse(17'h10000); checkVal(words, 10);
        apbDo(1, 16'h3D28, 32'h00);
    endtask
    task automatic modes;
        cpuMemBusy <= 1'b1;
        apbDo(1, 16'h3D10, 32'h70);
        apbDo(1, 16'h3D1C, 32'h71);
        expAddr = 22'h70;
        words = 0;
        apbDo(1, 16'h3D28, 32'hC2);
        repeat (10) @(posedge core_clk);
        checkVal(words, 0);
        checkVal({31'h0, cpuStall}, 32'h0);
        cpuMemBusy <= 1'b0;
        waitWords(2); checkVal(words, 2);
        crcReady <= 1'b0;
        apbDo(1, 16'h3D10, 32'h80);
        apbDo(1, 16'h3D1C, 32'h80);
        expAddr = 22'h80;
        words = 0;
        apbDo(1, 16'h3D28, 32'hC1);
        @(posedge core_clk);
        checkVal({31'h0, cpuStall}, 32'h1);
        crcReady <= 1'b1;
        waitWords(1); checkVal(words, 1);
        checkVal({31'h0, cpuStall}, 32'h0);
        apbDo(1, 16'h3D28, 32'h00);
    endtask
    task automatic give_verdict;
        $display("errors %0d compares %0d", fail_count, cmp_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        give_verdict;
    end
    initial begin
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        resetValues;
        badStart;
        scanRun;
        rollover;
        intrHold;
        disableKeeps;
        triggered;
        modes;
        give_verdict;
    end
endmodule
`default_nettype wire
